// ==== ast_transceiver.sv ====
// What this block does
// - NRZ frame: start, 8/9 data, stop.
// - LSB first, shared format and rate.
// - Baud prescale x16 high speed, x64 low.
// - No hardware parity; ninth bit carries it.
// - Baud generator halts during sleep.
// - Asynchronous only when clocked-mode bit clear.
// - Reload shifter only after stop bit sent.
// - Empty flag clears only on buffer write.
// - Shifter-empty status bit is polled.
// - Setting transmit enable sets empty flag.
// - Send needs enable and data, not a baud tick.
// - Clearing enable aborts and floats pin.
// - Receiver runs when continuous enable set.
// - Recovery sampler runs at x16 baud.
// - After stop bit push FIFO, set full.
// - Receive-full clears when FIFO emptied.
// - Two-entry FIFO; third word overruns, dropped.
// - Overrun blocks pushes; enable toggle clears.
// - Stop bit low sets framing error.
// - Error and ninth bit follow FIFO head.
// - Majority vote of samples 7, 8, 9.
// - Rate is clock over prescale times divisor+1.
// - Divisor write restarts baud timer.
//
// Decided for this implementation: the strobed register port.
`include "ast_defines.svh"

module ast_transceiver
    import ast_pkg::*;
#(
    parameter int RX_DEPTH = 2
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // Device power state.
    input wire logic sleepMode,
    // Register port.
    input wire ast_bus_req_t busReq,
    output logic [7:0] busRdData,
    // Serial line.
    input wire logic receivePin,
    output logic transmitPinOut,
    output logic transmitPinOe
);

    localparam int PTR_W = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
    localparam logic [PTR_W:0] FIFO_FULL = (PTR_W + 1)'(RX_DEPTH);

    // The pointer arithmetic wraps naturally only for a power-of-two depth.
    if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : gBadDepth
        $error("RX_DEPTH must be a power of two of at least 2");
    end

    // Decodes a write or read of one register address.
    function automatic logic hitWr(input ast_bus_req_t req, input logic [7:0] addr);
        return req.wr && (req.addr == addr);
    endfunction

    function automatic logic hitRd(input ast_bus_req_t req, input logic [7:0] addr);
        return req.rd && (req.addr == addr);
    endfunction

    // Two of three samples decide the bit level.
    function automatic logic majority(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    logic wrTxCtl, wrRxCtl, wrTxBuf, wrDivisor, wrEnables, rdRxBuf;
    assign wrTxCtl = hitWr(busReq, `AST_ADDR_TXCTL);
    assign wrRxCtl = hitWr(busReq, `AST_ADDR_RXCTL);
    assign wrTxBuf = hitWr(busReq, `AST_ADDR_TXBUF);
    assign wrDivisor = hitWr(busReq, `AST_ADDR_DIVISOR);
    assign wrEnables = hitWr(busReq, `AST_ADDR_ENABLES);
    assign rdRxBuf = hitRd(busReq, `AST_ADDR_RXBUF);

    // Control registers.
    logic clkSrc, txNineEn, transmit_enable, clockedMode, hiSpeed, txNinthBit;
    logic portEn, rxNineEn, singleRx, contRx;
    logic [7:0] irqEnables, baudDiv;
    logic next_clkSrc, next_txNineEn, next_transmit_enable, next_clockedMode, next_hiSpeed, next_txNinthBit;
    logic next_portEn, next_rxNineEn, next_singleRx, next_contRx;
    logic [7:0] next_irqEnables, next_baudDiv;

    // Software writes to the control registers.
    always_comb begin
        next_clkSrc = clkSrc;
        next_txNineEn = txNineEn;
        next_transmit_enable = transmit_enable;
        next_clockedMode = clockedMode;
        next_hiSpeed = hiSpeed;
        next_txNinthBit = txNinthBit;
        next_portEn = portEn;
        next_rxNineEn = rxNineEn;
        next_singleRx = singleRx;
        next_contRx = contRx;
        next_irqEnables = irqEnables;
        next_baudDiv = baudDiv;
        if (wrTxCtl) begin
            next_clkSrc = busReq.wdata[`AST_TX_CLKSRC];
            next_txNineEn = busReq.wdata[`AST_TX_NINE];
            next_transmit_enable = busReq.wdata[`AST_TX_EN];
            next_clockedMode = busReq.wdata[`AST_TX_CLOCKED];
            next_hiSpeed = busReq.wdata[`AST_TX_HISPEED];
            next_txNinthBit = busReq.wdata[`AST_TX_NINTHBIT];
        end
        if (wrRxCtl) begin
            next_portEn = busReq.wdata[`AST_RX_PORTEN];
            next_rxNineEn = busReq.wdata[`AST_RX_NINE];
            next_singleRx = busReq.wdata[`AST_RX_SINGLE];
            next_contRx = busReq.wdata[`AST_RX_CONT];
        end
        if (wrEnables) begin
            next_irqEnables = busReq.wdata;
        end
        if (wrDivisor) begin
            next_baudDiv = busReq.wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            clkSrc <= 1'b0;
            txNineEn <= 1'b0;
            transmit_enable <= 1'b0;
            clockedMode <= 1'b0;
            hiSpeed <= 1'b0;
            txNinthBit <= 1'b0;
            portEn <= 1'b0;
            rxNineEn <= 1'b0;
            singleRx <= 1'b0;
            contRx <= 1'b0;
            irqEnables <= `AST_RST_BYTE;
            baudDiv <= `AST_RST_BYTE;
        end else begin
            clkSrc <= next_clkSrc;
            txNineEn <= next_txNineEn;
            transmit_enable <= next_transmit_enable;
            clockedMode <= next_clockedMode;
            hiSpeed <= next_hiSpeed;
            txNinthBit <= next_txNinthBit;
            portEn <= next_portEn;
            rxNineEn <= next_rxNineEn;
            singleRx <= next_singleRx;
            contRx <= next_contRx;
            irqEnables <= next_irqEnables;
            baudDiv <= next_baudDiv;
        end
    end

    // Port is live only in asynchronous mode and enabled; sleep stops only the baud timer.
    logic asyncOn, txOn, rxOn;
    assign asyncOn = portEn && !clockedMode;
    assign txOn = asyncOn && transmit_enable;
    assign rxOn = asyncOn && contRx;

    // Baud generator.
    logic [7:0] baudCnt, next_baudCnt;
    logic [1:0] preCnt, next_preCnt;
    logic baudTick, osTick, baudRun;

    // Timer ticks once per divisor+1 clocks; low speed divides by four more.
    assign baudRun = (txOn || rxOn) && !sleepMode;
    assign baudTick = baudRun && (baudCnt == `AST_RST_BYTE);
    assign osTick = baudTick && (hiSpeed || preCnt == `AST_LOWSPEED_LAST);

    always_comb begin
        next_baudCnt = baudCnt;
        next_preCnt = preCnt;
        if (wrDivisor || !(txOn || rxOn)) begin
            next_baudCnt = wrDivisor ? busReq.wdata : baudDiv;
            next_preCnt = 2'h0;
        end else if (baudTick) begin
            next_baudCnt = baudDiv;
            next_preCnt = preCnt + 2'h1;
        end else if (baudRun) begin
            next_baudCnt = baudCnt - 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            baudCnt <= `AST_RST_BYTE;
            preCnt <= 2'h0;
        end else begin
            baudCnt <= next_baudCnt;
            preCnt <= next_preCnt;
        end
    end

    // Transmitter.
    ast_tx_state_t txState, next_txState;
    logic [7:0] txBuf, next_txBuf;
    logic txBufFull, next_txBufFull, txFlag, next_txFlag;
    logic [8:0] txShift, next_txShift;
    logic [3:0] txTick, next_txTick, txBit, next_txBit;
    logic txNine, next_txNine, next_txPinOut;
    logic txBitEnd, txLoad, txEnRise;

    assign txBitEnd = osTick && (txTick == `AST_OS_LAST);
    assign txEnRise = wrTxCtl && busReq.wdata[`AST_TX_EN] && !transmit_enable;
    // A load waits out a buffer write so the write never races the move.
    assign txLoad = txOn && txBufFull && !wrTxBuf
        && (txState == TX_IDLE || (txState == TX_STOP && txBitEnd));

    always_comb begin
        next_txState = txState;
        next_txBuf = txBuf;
        next_txBufFull = txBufFull;
        next_txFlag = txFlag;
        next_txShift = txShift;
        next_txTick = osTick ? txTick + 4'h1 : txTick;
        next_txBit = txBit;
        next_txNine = txNine;
        if (wrTxBuf) begin
            next_txBuf = busReq.wdata;
            next_txBufFull = 1'b1;
            next_txFlag = 1'b0;
        end
        if (txEnRise) begin
            next_txFlag = 1'b1;
        end
        if (!txOn) begin
            next_txState = TX_IDLE;
            next_txTick = 4'h0;
        end else if (txLoad) begin
            // The ninth bit is taken as it stands at the move.
            next_txShift = {txNinthBit, txBuf};
            next_txNine = txNineEn;
            next_txBufFull = 1'b0;
            next_txFlag = 1'b1;
            next_txState = TX_START;
            next_txTick = 4'h0;
            next_txBit = 4'h0;
        end else if (txBitEnd) begin
            case (txState)
                TX_START: begin
                    next_txState = TX_DATA;
                end
                TX_DATA: begin
                    next_txShift = {1'b0, txShift[8:1]};
                    next_txBit = txBit + 4'h1;
                    if (txBit == (txNine ? `AST_DATA9_LAST : `AST_DATA8_LAST)) begin
                        next_txState = TX_STOP;
                    end
                end
                TX_STOP: begin
                    next_txState = TX_IDLE;
                end
                default: begin
                    next_txState = TX_IDLE;
                end
            endcase
        end else if (txState == TX_IDLE) begin
            next_txTick = 4'h0;
        end
        // Line level per frame phase; idle and stop drive high.
        case (next_txState)
            TX_START: next_txPinOut = 1'b0;
            TX_DATA: next_txPinOut = next_txShift[0];
            default: next_txPinOut = 1'b1;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            txState <= TX_IDLE;
            txBuf <= `AST_RST_BYTE;
            txBufFull <= 1'b0;
            txFlag <= 1'b0;
            txShift <= 9'h000;
            txTick <= 4'h0;
            txBit <= 4'h0;
            txNine <= 1'b0;
            transmitPinOut <= 1'b1;
            transmitPinOe <= 1'b0;
        end else begin
            txState <= next_txState;
            txBuf <= next_txBuf;
            txBufFull <= next_txBufFull;
            txFlag <= next_txFlag;
            txShift <= next_txShift;
            txTick <= next_txTick;
            txBit <= next_txBit;
            txNine <= next_txNine;
            transmitPinOut <= next_txPinOut;
            transmitPinOe <= next_transmit_enable && next_portEn && !next_clockedMode;
        end
    end

    // Receiver.
    logic rxS1, rxS2, rxS3, rxLvl, rxLvlPrev, next_rxLvl;
    ast_rx_state_t rxState, next_rxState;
    logic [3:0] rxTick, next_rxTick, rxBit, next_rxBit;
    logic [2:0] rxVotes, next_rxVotes;
    logic [8:0] rxShift, next_rxShift;
    logic rxNine, next_rxNine, rxStopDone, rxStopErr, overrun, next_overrun;

    // The filtered level moves only when the last two stages agree.
    assign next_rxLvl = (rxS2 == rxS3) ? rxS3 : rxLvl;

    always_comb begin
        next_rxState = rxState;
        next_rxTick = osTick ? rxTick + 4'h1 : rxTick;
        next_rxBit = rxBit;
        next_rxVotes = rxVotes;
        next_rxShift = rxShift;
        next_rxNine = rxNine;
        rxStopDone = 1'b0;
        rxStopErr = 1'b0;
        if (osTick && rxTick >= `AST_VOTE_FIRST && rxTick <= `AST_VOTE_LAST) begin
            next_rxVotes = {rxVotes[1:0], rxLvl};
        end
        if (!rxOn) begin
            next_rxState = RX_IDLE;
            next_rxTick = 4'h0;
        end else begin
            case (rxState)
                RX_IDLE: begin
                    next_rxTick = 4'h0;
                    if (rxLvlPrev && !rxLvl) begin
                        next_rxState = RX_START;
                        next_rxNine = rxNineEn;
                        next_rxBit = 4'h0;
                    end
                end
                RX_START: begin
                    if (osTick && rxTick == `AST_OS_LAST) begin
                        next_rxState = majority(rxVotes) ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (osTick && rxTick == `AST_OS_LAST) begin
                        next_rxShift = {majority(rxVotes), rxShift[8:1]};
                        next_rxBit = rxBit + 4'h1;
                        if (rxBit == (rxNine ? `AST_DATA9_LAST : `AST_DATA8_LAST)) begin
                            next_rxState = RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (osTick && rxTick == `AST_STOP_DECIDE) begin
                        rxStopDone = 1'b1;
                        rxStopErr = !majority(rxVotes);
                        next_rxState = RX_IDLE;
                    end
                end
                default: begin
                    next_rxState = RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rxS1 <= 1'b1;
            rxS2 <= 1'b1;
            rxS3 <= 1'b1;
            rxLvl <= 1'b1;
            rxLvlPrev <= 1'b1;
            rxState <= RX_IDLE;
            rxTick <= 4'h0;
            rxBit <= 4'h0;
            rxVotes <= 3'h7;
            rxShift <= 9'h000;
            rxNine <= 1'b0;
        end else begin
            rxS1 <= receivePin;
            rxS2 <= rxS1;
            rxS3 <= rxS2;
            rxLvl <= next_rxLvl;
            rxLvlPrev <= rxLvl;
            rxState <= next_rxState;
            rxTick <= next_rxTick;
            rxBit <= next_rxBit;
            rxVotes <= next_rxVotes;
            rxShift <= next_rxShift;
            rxNine <= next_rxNine;
        end
    end

    // Receive FIFO.
    ast_rx_word_t rxMem [RX_DEPTH];
    ast_rx_word_t rxWord, rxHead;
    logic [PTR_W-1:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
    logic [PTR_W:0] fifoCnt, next_fifoCnt;
    logic rxPush, rxPop, rxFull;

    // An eight-bit word sits in the top of the shifter after eight shifts.
    assign rxWord = rxNine ? {rxStopErr, rxShift} : {rxStopErr, 1'b0, rxShift[8:1]};
    assign rxPush = rxStopDone && !overrun && fifoCnt != FIFO_FULL;
    assign rxPop = rdRxBuf && fifoCnt != '0;
    assign rxHead = (fifoCnt != '0) ? rxMem[rdPtr] : '0;
    assign rxFull = fifoCnt != '0;

    always_comb begin
        next_wrPtr = rxPush ? wrPtr + 1'b1 : wrPtr;
        next_rdPtr = rxPop ? rdPtr + 1'b1 : rdPtr;
        next_fifoCnt = fifoCnt + (PTR_W + 1)'(rxPush) - (PTR_W + 1)'(rxPop);
        next_overrun = overrun;
        if (!rxOn) begin
            next_overrun = 1'b0;
        end else if (rxStopDone && fifoCnt == FIFO_FULL) begin
            next_overrun = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            fifoCnt <= '0;
            overrun <= 1'b0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            fifoCnt <= next_fifoCnt;
            overrun <= next_overrun;
        end
    end

    // Storage needs no reset; the count guards every read.
    always_ff @(posedge ref_clk) begin
        if (rxPush) begin
            rxMem[wrPtr] <= rxWord;
        end
    end

    // Read port.
    logic [7:0] next_busRdData;

    always_comb begin
        next_busRdData = `AST_RST_BYTE;
        if (busReq.rd) begin
            case (busReq.addr)
                `AST_ADDR_FLAGS: begin
                    next_busRdData[`AST_FLAG_RXFULL] = rxFull;
                    next_busRdData[`AST_FLAG_TXEMPTY] = txFlag;
                end
                `AST_ADDR_RXCTL: begin
                    next_busRdData = {portEn, rxNineEn, singleRx, contRx, 1'b0,
                        rxHead.framErr, overrun, rxHead.ninth};
                end
                `AST_ADDR_TXBUF: next_busRdData = txBuf;
                `AST_ADDR_RXBUF: next_busRdData = rxHead.data;
                `AST_ADDR_ENABLES: next_busRdData = irqEnables;
                `AST_ADDR_TXCTL: begin
                    next_busRdData = {clkSrc, txNineEn, transmit_enable, clockedMode, 1'b0,
                        hiSpeed, txState == TX_IDLE, txNinthBit};
                end
                `AST_ADDR_DIVISOR: next_busRdData = baudDiv;
                default: next_busRdData = `AST_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busRdData <= `AST_RST_BYTE;
        end else begin
            busRdData <= next_busRdData;
        end
    end

    // Checks on the transmit, baud and receive paths.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence seqTxEnRise;
        txEnRise;
    endsequence

    sequence seqTxMove;
        txLoad;
    endsequence

    chk_tx_move_flag: assert property (seqTxMove |=> txFlag && !txBufFull)
        else $error("buffer move did not empty buffer and set flag");
    chk_tx_write_clears: assert property (wrTxBuf && !txEnRise |=> !txFlag && txBufFull)
        else $error("buffer write did not clear empty flag");
    chk_transmit_enable_sets_flag: assert property (seqTxEnRise |=> txFlag)
        else $error("transmit enable did not set empty flag");
    chk_tx_start_low: assert property (seqTxMove |=> !transmitPinOut ##1 !transmitPinOut)
        else $error("start bit not driven low");
    chk_tx_abort_float: assert property (txOn ##1 !txOn |=> !transmitPinOe && txState == TX_IDLE)
        else $error("transmit abort did not float pin");
    chk_tx_idle_high: assert property (transmitPinOe && txState == TX_IDLE |-> transmitPinOut)
        else $error("idle line not high");
    chk_sleep_no_tick: assert property (sleepMode |-> !osTick && !baudTick)
        else $error("baud generator ran during sleep");
    chk_div_restart: assert property (wrDivisor |=> baudCnt == baudDiv)
        else $error("divisor write did not restart timer");
    chk_rx_overrun: assert property (rxStopDone && fifoCnt == FIFO_FULL && rxOn
        |=> overrun && fifoCnt == FIFO_FULL - (PTR_W + 1)'($past(rxPop)))
        else $error("overrun not flagged or word kept");
    chk_rx_push_full: assert property (rxPush |=> rxFull)
        else $error("receive-full not set after push");

endmodule // ast_transceiver

// ==== ast_defines.svh ====
`ifndef AST_DEFINES_SVH
`define AST_DEFINES_SVH

// Register offsets on the plain register port.
`define AST_ADDR_FLAGS 8'h0C
`define AST_ADDR_RXCTL 8'h18
`define AST_ADDR_TXBUF 8'h19
`define AST_ADDR_RXBUF 8'h1A
`define AST_ADDR_ENABLES 8'h8C
`define AST_ADDR_TXCTL 8'h98
`define AST_ADDR_DIVISOR 8'h99

// Flag register bit positions.
`define AST_FLAG_RXFULL 5
`define AST_FLAG_TXEMPTY 4

// Transmit status/control bit positions.
`define AST_TX_CLKSRC 7
`define AST_TX_NINE 6
`define AST_TX_EN 5
`define AST_TX_CLOCKED 4
`define AST_TX_HISPEED 2
`define AST_TX_SHEMPTY 1
`define AST_TX_NINTHBIT 0

// Receive status/control bit positions.
`define AST_RX_PORTEN 7
`define AST_RX_NINE 6
`define AST_RX_SINGLE 5
`define AST_RX_CONT 4
`define AST_RX_FRAMERR 2
`define AST_RX_OVERRUN 1
`define AST_RX_NINTHBIT 0

// Reset values.
`define AST_RST_BYTE 8'h00
`define AST_RST_TXCTL 8'h02

// Oversampling timing in ticks of the x16 clock, plus the prescale and data-bit limits.
`define AST_OS_LAST 4'hF
`define AST_VOTE_FIRST 4'h6
`define AST_VOTE_LAST 4'h8
`define AST_STOP_DECIDE 4'h9
`define AST_LOWSPEED_LAST 2'h3
`define AST_DATA8_LAST 4'h7
`define AST_DATA9_LAST 4'h8

`endif

// ==== ast_pkg.sv ====
package ast_pkg;

    // Register port request from software.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ast_bus_req_t;

    // One received word as it sits in the receive FIFO.
    typedef struct packed {
        logic framErr;
        logic ninth;
        logic [7:0] data;
    } ast_rx_word_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_DATA = 2'b10,
        TX_STOP = 2'b11
    } ast_tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } ast_rx_state_t;

endpackage

// ==== ast_peer.sv ====
module ast_peer (
    // Clock.
    input wire logic ref_clk,
    // Line from the device and line towards it.
    input wire logic lineIn,
    output logic lineOut
);
    timeunit 1ns;
    timeprecision 1ps;
    int bitClks = 16;
    int nBits = 8;
    logic [9:0] got [$];
    logic [9:0] sh;

    initial lineOut = 1'b1;

    // Sends one frame, then one idle bit so the next start edge is clean.
    task automatic send(input logic [8:0] v, input logic stopLvl);
        lineOut <= 1'b0;
        repeat (bitClks) @(posedge ref_clk);
        for (int i = 0; i < nBits; i++) begin
            lineOut <= v[i];
            repeat (bitClks) @(posedge ref_clk);
        end
        lineOut <= stopLvl;
        repeat (bitClks) @(posedge ref_clk);
        lineOut <= 1'b1;
        repeat (bitClks) @(posedge ref_clk);
    endtask

    // Captures each frame at mid-bit; the stop level lands above the data.
    always begin
        @(negedge lineIn);
        sh = '0;
        repeat (bitClks / 2) @(posedge ref_clk);
        for (int i = 0; i <= nBits; i++) begin
            repeat (bitClks) @(posedge ref_clk);
            sh[i] = lineIn;
        end
        got.push_back(sh);
    end
endmodule // ast_peer

// ==== ast_transceiver_tb.sv ====
module ast_transceiver_tb;
    import ast_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic sleepMode = 1'b0;
    ast_bus_req_t busReq = '0;
    logic [7:0] busRdData;
    logic rxLine, txOut, txOe, txWire;
    int mismatches = 0;
    int nChecks = 0;
    int cycles = 0;
    logic [9:0] d;
    logic [24:0] rows [14] = '{25'h00C0000, 25'h0180000, 25'h0190000, 25'h01A0000, 25'h08C0000,
        25'h0980002, 25'h0990000, 25'h0550000, 25'h18CA5A5, 25'h1993C3C, 25'h10CFF00, 25'h1980103,
        25'h1980002, 25'h155FF00};

    // The line is pulled up while the device does not drive it.
    assign txWire = txOe ? txOut : 1'b1;

    ast_transceiver ast_transceiver_i (.ref_clk(ref_clk), .srst(srst), .sleepMode(sleepMode),
        .busReq(busReq), .busRdData(busRdData), .receivePin(rxLine), .transmitPinOut(txOut),
        .transmitPinOe(txOe));
    ast_peer ast_peer_i (.ref_clk(ref_clk), .lineIn(txWire), .lineOut(rxLine));

    // Free-running 40 MHz clock.
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Cuts a hang short.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    // Prints the verdict and ends the run.
    task automatic print_verdict();
        if (mismatches == 0 && nChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        nChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // One write cycle followed by an idle cycle.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        busReq.wr <= 1'b1;
        busReq.addr <= a;
        busReq.wdata <= v;
        @(posedge ref_clk);
        busReq.wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    // One read cycle; the data are taken in the cycle after it.
    task automatic rdChk(input logic [7:0] a, input logic [9:0] exp);
        busReq.rd <= 1'b1;
        busReq.addr <= a;
        @(posedge ref_clk);
        busReq.rd <= 1'b0;
        @(posedge ref_clk);
        d = {2'h0, busRdData};
        chk((exp[9:8] == 2'h1) ? (d & 10'h020) : d, {2'h0, exp[7:0]});
    endtask

    // Waits a bounded time for the peer to capture frames.
    task automatic waitFrames(input int n);
        for (int k = 0; k < 4000 && ast_peer_i.got.size() < n; k++) begin
            @(posedge ref_clk);
        end
    endtask

    // Main sequence: register table, transmit, abort, receive.
    initial begin
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        foreach (rows[i]) begin
            if (rows[i][24]) begin
                wr(rows[i][23:16], rows[i][15:8]);
            end
            rdChk(rows[i][23:16], {2'h0, rows[i][7:0]});
        end
        wr(8'h99, 8'h00);
        wr(8'h18, 8'h80);
        wr(8'h98, 8'h24);
        rdChk(8'h0C, 10'h010);
        wr(8'h19, 8'hA5);
        wr(8'h19, 8'h3C);
        rdChk(8'h0C, 10'h000);
        rdChk(8'h98, 10'h024);
        waitFrames(2);
        chk(ast_peer_i.got[0], 10'h1A5);
        chk(ast_peer_i.got[1], 10'h13C);
        repeat (20) @(posedge ref_clk);
        rdChk(8'h98, 10'h026);
        // Nine-bit frame at low speed after a divisor change.
        ast_peer_i.got.delete();
        ast_peer_i.nBits = 9;
        ast_peer_i.bitClks = 128;
        wr(8'h99, 8'h01);
        wr(8'h98, 8'h61);
        wr(8'h19, 8'h5A);
        waitFrames(1);
        chk(ast_peer_i.got[0], 10'h35A);
        repeat (80) @(posedge ref_clk);
        wr(8'h19, 8'h00);
        repeat (200) @(posedge ref_clk);
        wr(8'h98, 8'h00);
        @(posedge ref_clk);
        chk({9'h0, txOe}, 10'h000);
        rdChk(8'h98, 10'h002);
        repeat (1500) @(posedge ref_clk);
        ast_peer_i.nBits = 8;
        ast_peer_i.bitClks = 16;
        wr(8'h99, 8'h00);
        wr(8'h98, 8'h04);
        wr(8'h18, 8'h90);
        ast_peer_i.send(9'h011, 1'b1);
        ast_peer_i.send(9'h022, 1'b0);
        ast_peer_i.send(9'h033, 1'b1);
        repeat (8) @(posedge ref_clk);
        rdChk(8'h0C, 10'h120);
        rdChk(8'h18, 10'h092);
        rdChk(8'h1A, 10'h011);
        rdChk(8'h18, 10'h096);
        rdChk(8'h1A, 10'h022);
        rdChk(8'h0C, 10'h100);
        wr(8'h18, 8'h80);
        wr(8'h18, 8'hD0);
        rdChk(8'h18, 10'h0D0);
        ast_peer_i.nBits = 9;
        ast_peer_i.send(9'h1C4, 1'b1);
        repeat (8) @(posedge ref_clk);
        rdChk(8'h18, 10'h0D1);
        rdChk(8'h1A, 10'h0C4);
        // A frame started in sleep must hold its start bit until the device wakes.
        sleepMode <= 1'b1;
        wr(8'h98, 8'h24);
        wr(8'h19, 8'h77);
        repeat (40) @(posedge ref_clk);
        chk({9'h0, txOut}, 10'h000);
        rdChk(8'h98, 10'h024);
        sleepMode <= 1'b0;
        print_verdict();
    end
endmodule // ast_transceiver_tb
